// >>> src/core_exec.sv
// What this block does
// - next instruction fetched while the current one executes
// - 32 eight-bit registers, two read, up to two written per cycle (result and landing bus load)
// - six registers pair into three 16-bit data pointers, one for flash tables
// - instructions are one or two 16-bit words
// - flash self-write allowed only from the boot section, honouring lock bit 0 (bit 1 unused)
// - calls and interrupts push the return program counter to stack in SRAM
// - pending interrupt with lowest vector address is serviced first
// - 64 I/O addresses, also data space 0x20 to 0x5F
// - extended I/O 0x60 to 0xFF only by direct load and store
// - status register not saved or restored on interrupt entry and return
// - status at data 0x5F and I/O 0x3F, eight bits, reset zero
// - global enable clear blocks all interrupts
// - taking an interrupt clears global enable; interrupt return sets it
// - dedicated instructions set and clear global enable
// - bit store copies a register bit into status bit 6
// - bit load copies status bit 6 into one register bit
// - status bit 5 holds half carry from the low nibble
// - sign flag equals negative xor overflow
// - flags updated after every alu operation except move, pass, swap and no-op
// - bits 3..0 hold overflow, negative, zero and carry
//
// core execution datapath; assumes flash and data memory answer within the cycle
// (combinational read) and that instructions arrive pre-decoded by class.
`timescale 1ns/1ps
`default_nettype none
module core_exec
    import core_status_pkg::*;
(
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // program flash
    output logic [15:0] prog_addr,
    input wire logic [15:0] prog_word,
    input wire op_class_t dec_class,
    input wire alu_op_t dec_alu_op,
    input wire logic [4:0] dec_rd,
    input wire logic [4:0] dec_rr,
    input wire logic [7:0] dec_imm,
    input wire logic [2:0] dec_bit,
    input wire logic [1:0] dec_ptr,
    input wire logic dec_two_word,
    input wire logic [1:0] flash_lock,
    // data space
    output logic [15:0] data_addr,
    output logic [7:0] data_wdata,
    output logic data_we,
    output logic data_re,
    input wire logic [7:0] data_rdata,
    // flash self-write
    output logic flash_self_write_op,
    output logic [15:0] flash_wr_addr,
    // interrupts
    input wire logic [IRQ_W-1:0] irq_req,
    output logic [IRQ_W-1:0] irq_ack,
    // status
    output logic [7:0] processor_status_flags,
    output logic [15:0] program_counter,
    output logic [15:0] stack_pointer
);
    logic [7:0] regs_r [NUM_WORK_REGS];
    logic [7:0] psf_r;
    logic [15:0] pc_r;
    logic [15:0] sp_r;
    logic [15:0] fetch_addr_r;
    logic [15:0] ret_hold_r;
    logic [IRQ_W-1:0] ack_r;
    logic [15:0] daddr_r;
    logic [7:0] dwdata_r;
    logic dwe_r;
    logic dre_r;
    logic [4:0] ld_rd_r;
    logic spm_r;
    logic [15:0] spm_addr_r;
    exec_state_t state_r;
    exec_state_t state_nxt;

    logic [7:0] op_a;
    logic [7:0] op_b;
    logic [7:0] alu_res;
    logic [7:0] alu_flags;
    logic alu_wb;
    logic irq_take;
    logic [2:0] irq_idx;
    logic [15:0] ds_addr;
    logic [7:0] psf_nxt;
    logic [15:0] ptr_val;

    // 16-bit pointer from a register pair
    function automatic logic [15:0] pair_val(input logic [4:0] lo);
        pair_val = {regs_r[lo + 5'd1], regs_r[lo]};
    endfunction : pair_val

    // true for the status register's data-space address
    function automatic logic is_psf(input logic [15:0] a);
        is_psf = (a == PSF_DS_ADDR);
    endfunction : is_psf

    alu_op_t alu_op_sel;
    core_alu u_alu (
        .op(alu_op_sel),
        .a(op_a),
        .b(op_b),
        .flags_in(psf_r),
        .result(alu_res),
        .flags_out(alu_flags),
        .writes_back(alu_wb)
    );

    // two operands from the file; the second is dec_imm instead for load-immediate
    always_comb begin
        op_a = regs_r[dec_rd];
        op_b = (dec_class == CL_LDI) ? dec_imm : regs_r[dec_rr];
        alu_op_sel = (dec_class == CL_ALU) ? dec_alu_op : ALU_NOP;
    end

    // pointer selection: 0 direct, 1..3 the three pairs
    always_comb begin
        unique case (dec_ptr)
            2'd1: ptr_val = pair_val(PTR_A_LO);
            2'd2: ptr_val = pair_val(PTR_B_LO);
            2'd3: ptr_val = pair_val(PTR_C_LO);
            default: ptr_val = prog_word;
        endcase
    end

    // data address for I/O and direct loads and stores
    always_comb begin
        if (dec_class == CL_IN || dec_class == CL_OUT)
            ds_addr = {10'h000, dec_imm[5:0]} + IO_TO_DS_OFFSET;
        else
            ds_addr = ptr_val;
    end

    // lowest vector wins among enabled requests
    always_comb begin
        irq_idx = 3'd0;
        irq_take = 1'b0;
        for (int i = IRQ_W - 1; i >= 0; i--) begin
            if (irq_req[i]) begin
                irq_idx = i[2:0];
                irq_take = 1'b1;
            end
        end
        irq_take = irq_take & psf_r[FLAG_I] & (state_r == ST_RUN);
    end

    // next status value
    always_comb begin
        psf_nxt = psf_r;
        if (state_r == ST_RUN) begin
            if (irq_take) begin
                psf_nxt[FLAG_I] = 1'b0;
            end else begin
                unique case (dec_class)
                    CL_ALU: psf_nxt = alu_flags;
                    CL_BST: psf_nxt[FLAG_T] = regs_r[dec_rd][dec_bit];
                    CL_SEI: psf_nxt[FLAG_I] = 1'b1;
                    CL_CLI: psf_nxt[FLAG_I] = 1'b0;
                    CL_RETURN_FROM_INTERRUPT_OP: psf_nxt[FLAG_I] = 1'b1;
                    CL_OUT, CL_STS: begin
                        if (is_psf(ds_addr))
                            psf_nxt = regs_r[dec_rd];
                    end
                    default: psf_nxt = psf_r;
                endcase
            end
        end
    end

    // status register
    always_ff @(posedge clk_sys) begin
        if (rst)
            psf_r <= PSF_RESET;
        else
            psf_r <= psf_nxt;
    end

    // register file writes
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            for (int i = 0; i < NUM_WORK_REGS; i++)
                regs_r[i] <= 8'h00;
        end else if (state_r == ST_RUN && !irq_take) begin
            unique case (dec_class)
                CL_ALU: if (alu_wb) regs_r[dec_rd] <= alu_res;
                CL_LDI: regs_r[dec_rd] <= dec_imm;
                CL_BLD: regs_r[dec_rd][dec_bit] <= psf_r[FLAG_T];
                CL_IN, CL_LDS: if (is_psf(ds_addr)) regs_r[dec_rd] <= psf_r;
                default: ;
            endcase
        end
        // a bus load lands one cycle after its strobe; the next instruction sees the old value
        if (!rst && dre_r)
            regs_r[ld_rd_r] <= data_rdata;
    end

    // execution state machine
    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            ST_RUN: begin
                if (irq_take || dec_class == CL_CALL)
                    state_nxt = ST_PUSHHI;
                else if (dec_two_word && dec_class != CL_LDS && dec_class != CL_STS)
                    state_nxt = ST_WORD2;
            end
            ST_WORD2: state_nxt = ST_RUN;
            ST_PUSHHI: state_nxt = ST_RUN;
            default: state_nxt = ST_RUN;
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (rst)
            state_r <= ST_RUN;
        else
            state_r <= state_nxt;
    end

    // program counter and prefetch address
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            pc_r <= PC_RESET;
            fetch_addr_r <= PC_RESET;
            ret_hold_r <= PC_RESET;
        end else if (state_r == ST_RUN) begin
            if (irq_take) begin
                ret_hold_r <= pc_r;
                pc_r <= {12'h000, irq_idx, 1'b0} + 16'h0002;
                fetch_addr_r <= {12'h000, irq_idx, 1'b0} + 16'h0002;
            end else if (dec_class == CL_CALL || dec_class == CL_JMP) begin
                ret_hold_r <= pc_r + 16'h0002;
                pc_r <= prog_word;
                fetch_addr_r <= prog_word;
            end else if (dec_class == CL_RET || dec_class == CL_RETURN_FROM_INTERRUPT_OP) begin
                pc_r <= {data_rdata, 8'h00};
                fetch_addr_r <= {data_rdata, 8'h00};
            end else begin
                pc_r <= pc_r + (dec_two_word ? 16'h0002 : 16'h0001);
                fetch_addr_r <= pc_r + (dec_two_word ? 16'h0002 : 16'h0001) + 16'h0001;
            end
        end else begin
            fetch_addr_r <= fetch_addr_r;
        end
    end

    // stack pointer: two-byte push on call and interrupt, pop on return
    always_ff @(posedge clk_sys) begin
        if (rst)
            sp_r <= SP_RESET;
        else if (state_r == ST_RUN && (irq_take || dec_class == CL_CALL))
            sp_r <= sp_r - 16'h0001;
        else if (state_r == ST_PUSHHI)
            sp_r <= sp_r - 16'h0001;
        else if (state_r == ST_RUN && (dec_class == CL_RET || dec_class == CL_RETURN_FROM_INTERRUPT_OP))
            sp_r <= sp_r + 16'h0002;
    end

    // data bus drive: stack pushes, stores outside the register file except to status, and every load except of status
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            daddr_r <= 16'h0000;
            dwdata_r <= 8'h00;
            dwe_r <= 1'b0;
            dre_r <= 1'b0;
            ld_rd_r <= 5'h00;
        end else begin
            dwe_r <= 1'b0;
            dre_r <= 1'b0;
            if (state_r == ST_RUN && (irq_take || dec_class == CL_CALL)) begin
                daddr_r <= sp_r;
                dwdata_r <= irq_take ? pc_r[7:0] : pc_r[7:0] + 8'h02;
                dwe_r <= 1'b1;
            end else if (state_r == ST_PUSHHI) begin
                daddr_r <= sp_r;
                dwdata_r <= ret_hold_r[15:8];
                dwe_r <= 1'b1;
            end else if (state_r == ST_RUN && (dec_class == CL_OUT || dec_class == CL_STS)
                         && !is_psf(ds_addr) && ds_addr > DS_REGFILE_END
                         && (dec_class == CL_STS || ds_addr <= DS_IO_LAST)) begin
                daddr_r <= ds_addr;
                dwdata_r <= regs_r[dec_rd];
                dwe_r <= 1'b1;
            end else if (state_r == ST_RUN && (dec_class == CL_IN || dec_class == CL_LDS)
                         && !is_psf(ds_addr)) begin
                daddr_r <= ds_addr;
                dre_r <= 1'b1;
                ld_rd_r <= dec_rd;
            end
        end
    end

    // flash self-write only from boot section and when unlocked
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            spm_r <= 1'b0;
            spm_addr_r <= 16'h0000;
        end else begin
            spm_r <= (state_r == ST_RUN) && !irq_take && (dec_class == CL_SPM)
                     && (pc_r >= BOOT_START) && !flash_lock[0];
            spm_addr_r <= pair_val(PTR_C_LO);
        end
    end

    // interrupt acknowledge pulse
    always_ff @(posedge clk_sys) begin
        if (rst)
            ack_r <= '0;
        else
            ack_r <= irq_take ? (IRQ_W'(1) << irq_idx) : '0;
    end

    // outputs from flip-flops
    assign prog_addr = fetch_addr_r;
    assign data_addr = daddr_r;
    assign data_wdata = dwdata_r;
    assign data_we = dwe_r;
    assign data_re = dre_r;
    assign flash_self_write_op = spm_r;
    assign flash_wr_addr = spm_addr_r;
    assign irq_ack = ack_r;
    assign processor_status_flags = psf_r;
    assign program_counter = pc_r;
    assign stack_pointer = sp_r;
endmodule : core_exec
`default_nettype wire

// >>> src/core_status_pkg.sv
// shared constants for the 8-bit core datapath and its status flags
// assumes a single 50 MHz system clock and synchronous active-high reset
package core_status_pkg;
    // clock
    localparam int CLK_PERIOD_NS = 20;
    // register file shape
    localparam int NUM_WORK_REGS = 32;
    localparam int REG_IDX_W = 5;
    // pointer pairs (low byte index of each pair)
    localparam logic [4:0] PTR_A_LO = 5'h1A;
    localparam logic [4:0] PTR_B_LO = 5'h1C;
    localparam logic [4:0] PTR_C_LO = 5'h1E;
    // data space windows
    localparam logic [15:0] DS_REGFILE_END = 16'h001F;
    localparam logic [15:0] DS_IO_BASE = 16'h0020;
    localparam logic [15:0] DS_IO_LAST = 16'h005F;
    localparam logic [15:0] DS_XIO_BASE = 16'h0060;
    localparam logic [15:0] DS_XIO_LAST = 16'h00FF;
    localparam int IO_COUNT = 64;
    localparam logic [15:0] IO_TO_DS_OFFSET = 16'h0020;
    // status register
    localparam logic [15:0] PSF_DS_ADDR = 16'h005F;
    localparam logic [5:0] PSF_IO_ADDR = 6'h3F;
    localparam logic [7:0] PSF_RESET = 8'h00;
    localparam int FLAG_I = 7;
    localparam int FLAG_T = 6;
    localparam int FLAG_H = 5;
    localparam int FLAG_S = 4;
    localparam int FLAG_V = 3;
    localparam int FLAG_N = 2;
    localparam int FLAG_Z = 1;
    localparam int FLAG_C = 0;
    // program memory
    localparam int PC_W = 16;
    localparam logic [15:0] PC_RESET = 16'h0000;
    localparam logic [15:0] BOOT_START = 16'h3800;
    localparam int IRQ_W = 8;
    localparam int SP_W = 16;
    localparam logic [15:0] SP_RESET = 16'h08FF;
    // alu operation codes
    typedef enum logic [3:0] {
        ALU_ADD = 4'h0, ALU_ADC = 4'h1, ALU_SUB = 4'h2, ALU_SBC = 4'h3,
        ALU_AND = 4'h4, ALU_OR = 4'h5, ALU_EOR = 4'h6, ALU_MOV = 4'h7,
        ALU_LSR = 4'h8, ALU_COM = 4'h9, ALU_INC = 4'hA, ALU_DEC = 4'hB,
        ALU_CMP = 4'hC, ALU_PASS = 4'hD, ALU_SWAP = 4'hE, ALU_NOP = 4'hF
    } alu_op_t;
    // pre-decoded instruction classes
    typedef enum logic [3:0] {
        CL_NOP = 4'h0, CL_ALU = 4'h1, CL_LDI = 4'h2, CL_BST = 4'h3,
        CL_BLD = 4'h4, CL_SEI = 4'h5, CL_CLI = 4'h6, CL_IN = 4'h7,
        CL_OUT = 4'h8, CL_LDS = 4'h9, CL_STS = 4'hA, CL_CALL = 4'hB,
        CL_RET = 4'hC, CL_RETURN_FROM_INTERRUPT_OP = 4'hD, CL_JMP = 4'hE, CL_SPM = 4'hF
    } op_class_t;
    // execution state
    typedef enum logic [2:0] {
        ST_RUN = 3'b001, ST_WORD2 = 3'b010, ST_PUSHHI = 3'b100
    } exec_state_t;
endpackage : core_status_pkg

// >>> src/core_alu.sv
// single-cycle 8-bit alu with flag generation
// assumes operands come straight from the register file in the same cycle
`timescale 1ns/1ps
`default_nettype none
module core_alu
    import core_status_pkg::*;
(
    // operation
    input wire alu_op_t op,
    input wire logic [7:0] a,
    input wire logic [7:0] b,
    input wire logic [7:0] flags_in,
    // result
    output logic [7:0] result,
    output logic [7:0] flags_out,
    output logic writes_back
);
    logic [8:0] sum;
    logic cin;
    logic hc;
    logic vf;
    logic cf;
    logic nf;

    // arithmetic and logic with H, V, N, Z, C generation
    always_comb begin
        flags_out = flags_in;
        cin = flags_in[FLAG_C];
        sum = 9'h000;
        hc = flags_in[FLAG_H];
        vf = 1'b0;
        cf = flags_in[FLAG_C];
        writes_back = 1'b1;
        result = a;
        unique case (op)
            ALU_ADD, ALU_ADC: begin
                sum = {1'b0, a} + {1'b0, b} + {8'h00, (op == ALU_ADC) & cin};
                result = sum[7:0];
                hc = (a[3] & b[3]) | (b[3] & ~result[3]) | (~result[3] & a[3]);
                vf = (a[7] & b[7] & ~result[7]) | (~a[7] & ~b[7] & result[7]);
                cf = sum[8];
            end
            ALU_SUB, ALU_SBC, ALU_CMP: begin
                sum = {1'b0, a} - {1'b0, b} - {8'h00, (op == ALU_SBC) & cin};
                result = sum[7:0];
                hc = (~a[3] & b[3]) | (b[3] & result[3]) | (result[3] & ~a[3]);
                vf = (a[7] & ~b[7] & ~result[7]) | (~a[7] & b[7] & result[7]);
                cf = sum[8];
                writes_back = (op != ALU_CMP);
            end
            ALU_AND: result = a & b;
            ALU_OR: result = a | b;
            ALU_EOR: result = a ^ b;
            ALU_MOV, ALU_PASS: result = b;
            ALU_LSR: begin
                result = {1'b0, a[7:1]};
                cf = a[0];
                vf = a[0];
            end
            ALU_COM: begin
                result = ~a;
                cf = 1'b1;
            end
            ALU_INC: begin
                result = a + 8'h01;
                vf = (a == 8'h7F);
            end
            ALU_DEC: begin
                result = a - 8'h01;
                vf = (a == 8'h80);
            end
            ALU_SWAP: result = {a[3:0], a[7:4]};
            ALU_NOP: writes_back = 1'b0;
        endcase
        nf = result[7];
        // flags follow the result of each operation except move, pass, swap and no-op
        if (op != ALU_MOV && op != ALU_PASS && op != ALU_SWAP && op != ALU_NOP) begin
            flags_out[FLAG_N] = nf;
            flags_out[FLAG_Z] = (result == 8'h00);
            flags_out[FLAG_V] = vf;
            flags_out[FLAG_S] = nf ^ vf;
            flags_out[FLAG_C] = cf;
            flags_out[FLAG_H] = hc;
        end
    end
endmodule : core_alu
`default_nettype wire

// >>> test/core_status_checker.sv
// assertions on status flags, interrupt entry and data strobes of the core
// assumes one clock clk_sys and synchronous active-high rst
`timescale 1ns/1ps
`default_nettype none
module core_status_checker
    import core_status_pkg::*;
(
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // instruction and requests
    input wire op_class_t dec_class,
    input wire alu_op_t dec_alu_op,
    input wire logic [7:0] dec_imm,
    input wire logic dec_two_word,
    input wire logic [IRQ_W-1:0] irq_req,
    // observed outputs
    input wire logic [15:0] data_addr,
    input wire logic data_we,
    input wire logic [IRQ_W-1:0] irq_ack,
    input wire logic [7:0] processor_status_flags,
    input wire logic [15:0] program_counter
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (rst);
    logic quiet;
    // no interrupt or second word can steal the executing edge
    assign quiet = (irq_req == '0) && (irq_ack == '0) && !dec_two_word;
    // return address goes out as two bytes at falling addresses
    sequence push_two;
        data_we ##1 (data_we && data_addr == $past(data_addr) - 16'h0001);
    endsequence
    a_reset_values: assert property (
        $fell(rst) |-> processor_status_flags == PSF_RESET && program_counter == PC_RESET)
        else $error("status or pc not at reset value");
    a_sign_rule: assert property (
        (dec_class == CL_ALU && quiet && dec_alu_op inside {ALU_ADD, ALU_SUB, ALU_AND})
        |=> processor_status_flags[FLAG_S] ==
            (processor_status_flags[FLAG_N] ^ processor_status_flags[FLAG_V]))
        else $error("sign flag differs from negative xor overflow");
    a_enable_on: assert property (
        (dec_class == CL_SEI && quiet) |=> processor_status_flags[FLAG_I])
        else $error("set-enable left global enable clear");
    a_enable_off: assert property (
        (dec_class == CL_CLI && quiet) |=> !processor_status_flags[FLAG_I])
        else $error("clear-enable left global enable set");
    a_return_enable: assert property (
        (dec_class == CL_RETURN_FROM_INTERRUPT_OP && quiet) |=> processor_status_flags[FLAG_I])
        else $error("interrupt return did not set global enable");
    a_irq_blocked: assert property (
        !processor_status_flags[FLAG_I] |=> irq_ack == '0)
        else $error("interrupt taken with global enable clear");
    a_ack_lowest: assert property (
        irq_ack != '0 |-> !processor_status_flags[FLAG_I] &&
            irq_ack == ($past(irq_req) & (~$past(irq_req) + 8'h01)))
        else $error("ack not lowest request or enable not cleared");
    a_push_pair: assert property (
        irq_ack != '0 |-> push_two)
        else $error("return address not pushed as two bytes");
    a_io_window: assert property (
        (dec_class == CL_OUT && quiet && dec_imm[5:0] != PSF_IO_ADDR)
        |=> data_we && data_addr == ({8'h00, $past(dec_imm)} & 16'h003F) + IO_TO_DS_OFFSET)
        else $error("io write not mapped above the register file");
endmodule : core_status_checker
`default_nettype wire

// >>> test/data_space_model.sv
// data space and flash stand-in facing the execution core
// assumes combinational reads on data_re and writes on the rising edge
`timescale 1ns/1ps
`default_nettype none
module data_space_model (
    // clock
    input wire logic clk_sys,
    // data space
    input wire logic [15:0] data_addr,
    input wire logic [7:0] data_wdata,
    input wire logic data_we,
    input wire logic data_re,
    output logic [7:0] data_rdata,
    // program flash
    input wire logic [15:0] prog_addr,
    output logic [15:0] prog_word
);
    logic [7:0] mem_r [0:4095];
    logic [7:0] last_r = 8'h00;
    // stores land on the edge; the read value is kept for the idle bus
    always_ff @(posedge clk_sys) begin
        if (data_we) begin
            mem_r[data_addr[11:0]] <= data_wdata;
        end
        if (data_re) begin
            last_r <= data_rdata;
        end
    end
    // an unselected bus shows the inverse of the last value
    assign data_rdata = data_re ? mem_r[data_addr[11:0]] : ~last_r;
    // flash word derived from the low address byte, repeating every 256 words
    assign prog_word = {prog_addr[7:0], ~prog_addr[7:0]};
endmodule : data_space_model
`default_nettype wire

// >>> test/cpu_core_status_flags_bench.sv
// self-checking bench for status flags, interrupt entry and io mapping
// assumes the data space model answers reads in the same cycle
`timescale 1ns/1ps
`default_nettype none
module cpu_core_status_flags_bench
    import core_status_pkg::*;
;
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    op_class_t dec_class = CL_NOP;
    alu_op_t dec_alu_op = ALU_NOP;
    logic [4:0] dec_rd = 5'h00;
    logic [4:0] dec_rr = 5'h00;
    logic [7:0] dec_imm = 8'h00;
    logic [2:0] dec_bit = 3'h0;
    logic [1:0] dec_ptr = 2'h0;
    logic dec_two_word = 1'b0;
    logic [1:0] flash_lock = 2'h0;
    logic [IRQ_W-1:0] irq_req = '0;
    logic [IRQ_W-1:0] irq_ack;
    logic [15:0] prog_addr, prog_word, data_addr, flash_wr_addr, program_counter, stack_pointer;
    logic [7:0] data_wdata, data_rdata, processor_status_flags;
    logic data_we, data_re, flash_self_write_op;
    int err_total = 0;
    int n_compared = 0;
    // expected flags: overflow into sign, wrap to zero, equal, borrow
    logic [7:0] alu_a [4] = '{8'h7F, 8'hFF, 8'h01, 8'h00};
    alu_op_t alu_k [4] = '{ALU_ADD, ALU_ADD, ALU_SUB, ALU_SUB};
    logic [7:0] alu_f [4] = '{8'h2C, 8'h23, 8'h02, 8'h35};
    // clock
    always #(CLK_PERIOD_NS / 2) clk_sys = ~clk_sys;
    // design and far side
    core_exec dut_u (
        .clk_sys(clk_sys), .rst(rst), .prog_addr(prog_addr), .prog_word(prog_word),
        .dec_class(dec_class), .dec_alu_op(dec_alu_op), .dec_rd(dec_rd), .dec_rr(dec_rr),
        .dec_imm(dec_imm), .dec_bit(dec_bit), .dec_ptr(dec_ptr), .dec_two_word(dec_two_word),
        .flash_lock(flash_lock), .data_addr(data_addr), .data_wdata(data_wdata),
        .data_we(data_we), .data_re(data_re), .data_rdata(data_rdata),
        .flash_self_write_op(flash_self_write_op), .flash_wr_addr(flash_wr_addr),
        .irq_req(irq_req), .irq_ack(irq_ack), .processor_status_flags(processor_status_flags),
        .program_counter(program_counter), .stack_pointer(stack_pointer));
    data_space_model model_u (
        .clk_sys(clk_sys), .data_addr(data_addr), .data_wdata(data_wdata), .data_we(data_we),
        .data_re(data_re), .data_rdata(data_rdata), .prog_addr(prog_addr),
        .prog_word(prog_word));
    // compare and count
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp) begin
            err_total++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    task automatic chk8(input logic [7:0] seen, input logic [7:0] exp);
        check({8'h00, seen}, {8'h00, exp});
    endtask : chk8
    // present one instruction at a falling edge; results visible one cycle on
    task automatic op(input op_class_t c, input alu_op_t a, input logic [4:0] r,
                      input logic [4:0] s, input logic [7:0] imm, input logic [2:0] b);
        dec_class = c;
        dec_alu_op = a;
        dec_rd = r;
        dec_rr = s;
        dec_imm = imm;
        dec_bit = b;
        @(negedge clk_sys);
    endtask : op
    task automatic ldi(input logic [4:0] r, input logic [7:0] v);
        op(CL_LDI, ALU_NOP, r, r, v, 3'h0);
    endtask : ldi
    task automatic out(input logic [5:0] io, input logic [4:0] r);
        op(CL_OUT, ALU_NOP, r, r, {2'h0, io}, 3'h0);
    endtask : out
    task automatic psf(input logic [7:0] v);
        ldi(5'h10, v);
        out(PSF_IO_ADDR, 5'h10);
    endtask : psf
    task automatic idle(input int n);
        dec_class = CL_NOP;
        repeat (n) @(negedge clk_sys);
    endtask : idle
    task automatic end_test(input string name);
        $display("test %s done, mismatches so far %0d", name, err_total);
    endtask : end_test
    task automatic finish_test;
        $display("compared %0d, mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : finish_test
    // test sequence
    initial begin
        repeat (12) @(negedge clk_sys);
        rst = 1'b0;
        chk8(processor_status_flags, PSF_RESET);
        end_test("reset");
        psf(8'hA5);
        chk8(processor_status_flags, 8'hA5);
        check(prog_addr, 16'h0003);
        check(program_counter, 16'h0002);
        op(CL_IN, ALU_NOP, 5'h12, 5'h12, 8'h3F, 3'h0);
        out(6'h02, 5'h12);
        check(data_addr, 16'h0022);
        chk8(data_wdata, 8'hA5);
        op(CL_IN, ALU_NOP, 5'h13, 5'h13, 8'h02, 3'h0);
        chk8({7'h00, data_re}, 8'h01);
        idle(1);
        out(6'h03, 5'h13);
        chk8(data_wdata, 8'hA5);
        end_test("status access");
        psf(8'h15);
        op(CL_SEI, ALU_NOP, 5'h00, 5'h00, 8'h00, 3'h0);
        chk8(processor_status_flags, 8'h95);
        op(CL_CLI, ALU_NOP, 5'h00, 5'h00, 8'h00, 3'h0);
        chk8(processor_status_flags, 8'h15);
        irq_req = 8'h06;
        idle(2);
        chk8(irq_ack, 8'h00);
        op(CL_SEI, ALU_NOP, 5'h00, 5'h00, 8'h00, 3'h0);
        idle(1);
        chk8(irq_ack, 8'h02);
        chk8(processor_status_flags, 8'h15);
        check(program_counter, 16'h0004);
        check(data_addr, SP_RESET);
        irq_req = '0;
        idle(1);
        check(data_addr, SP_RESET - 16'h0001);
        chk8({7'h00, data_we}, 8'h01);
        check(stack_pointer, SP_RESET - 16'h0002);
        op(CL_RETURN_FROM_INTERRUPT_OP, ALU_NOP, 5'h00, 5'h00, 8'h00, 3'h0);
        chk8(processor_status_flags, 8'h95);
        check(stack_pointer, SP_RESET);
        end_test("interrupt");
        ldi(5'h14, 8'h08);
        op(CL_BST, ALU_NOP, 5'h14, 5'h14, 8'h00, 3'h3);
        chk8(processor_status_flags, 8'hD5);
        ldi(5'h15, 8'h81);
        op(CL_BLD, ALU_NOP, 5'h15, 5'h15, 8'h00, 3'h5);
        out(6'h01, 5'h15);
        chk8(data_wdata, 8'hA1);
        op(CL_BST, ALU_NOP, 5'h14, 5'h14, 8'h00, 3'h2);
        chk8(processor_status_flags, 8'h95);
        end_test("bit copy");
        psf(8'h00);
        for (int i = 0; i < 4; i++) begin
            ldi(5'h10, alu_a[i]);
            ldi(5'h11, 8'h01);
            op(CL_ALU, alu_k[i], 5'h10, 5'h11, 8'h00, 3'h0);
            chk8(processor_status_flags, alu_f[i]);
        end
        end_test("alu flags");
        // the return landed in the boot section, so only the lock refuses
        flash_lock = 2'h1;
        op(CL_SPM, ALU_NOP, 5'h00, 5'h00, 8'h00, 3'h0);
        chk8({7'h00, flash_self_write_op}, 8'h00);
        flash_lock = 2'h0;
        op(CL_SPM, ALU_NOP, 5'h00, 5'h00, 8'h00, 3'h0);
        chk8({7'h00, flash_self_write_op}, 8'h01);
        check(flash_wr_addr, 16'h0000);
        idle(1);
        end_test("self write");
        finish_test();
    end
    // watchdog
    initial begin
        repeat (5000) @(posedge clk_sys);
        err_total++;
        finish_test();
    end
endmodule : cpu_core_status_flags_bench
bind core_exec core_status_checker chk_u (
    .clk_sys(clk_sys), .rst(rst), .dec_class(dec_class), .dec_alu_op(dec_alu_op),
    .dec_imm(dec_imm), .dec_two_word(dec_two_word), .irq_req(irq_req),
    .data_addr(data_addr), .data_we(data_we), .irq_ack(irq_ack),
    .processor_status_flags(processor_status_flags), .program_counter(program_counter));
`default_nettype wire
